// >>> hdl/vme_regs.v
// voice and modem expansion devices: select, registers, status, firmware RAM
//
// Contract
// RULE1 - 512-byte firmware RAM at D600-D7FF
// RULE2 - all interrupt status read at D1FF only
// RULE3 - voice device is select bit 7
// RULE4 - D100-D103 write loads enable and phoneme
// RULE5 - D104-D107 write sends latched phoneme out
// RULE6 - phoneme request sets status bit 7, interrupt
// RULE7 - status bit 7 ignores the enable bit
// RULE8 - modem device is select bit 1
// RULE9 - D108-D10B loads modem control, bit7 attention
// RULE10 - bits 6,5,4: loopback, phone audio, off hook
// RULE11 - bit 3 mixes audio, bit 2 cuts direct
// RULE12 - bit 1 originate/answer, bit 0 squelch carrier
// RULE13 - serial interface registers at D10C-D10F
// RULE14 - serial interrupt is status bit 1, interrupt
// RULE15 - carrier to DCD, ring to DSR, CTS low
// RULE16 - reset clears serial interface, control to 00
// RULE17 - host dials by hook toggling or tones
// RULE18 - voice interrupt needs request and enable
`include "vme_map.vh"

module vme_regs #(
    parameter RAM_AW    = `VME_RAM_AW,
    parameter RAM_DEPTH = `VME_RAM_DEPTH,
    parameter STROBE_NS = `VME_STROBE_NS,
    parameter CLK_MHZ   = `VME_CLK_MHZ
) (
    // clock and reset
    input  wire       clk,
    input  wire       rst,
    // host expansion bus, strobes are one clock wide
    input  wire [15:0] busAddr,
    input  wire [7:0]  busWrData,
    input  wire        busWrStrobe,
    input  wire        busRdStrobe,
    output reg  [7:0]  busRdData,
    output reg         busRdDataEn,
    output reg         busIrq,
    // speech synthesizer
    input  wire        synthRequest,
    output reg  [5:0]  synthPhoneme,
    output reg         synthStrobe,
    // modem and audio routing
    output reg         diskAttention,
    output reg         modemLoopback,
    output reg         phoneAudioOn,
    output reg         lineOffHook,
    output reg         auxAudioMix,
    output reg         directAudioCut,
    output reg         modemOriginate,
    output reg         carrierSquelch,
    input  wire        carrierDetect_n,
    input  wire        ringDetect_n,
    // serial communications interface
    output reg         serialSelect,
    output reg  [1:0]  serialRegSel,
    output reg         serialWrite,
    output reg  [7:0]  serialWrData,
    input  wire [7:0]  serialRdData,
    input  wire        serialIrq_n,
    output reg         serialReset,
    output reg         serialDcd_n,
    output reg         serialDsr_n,
    output wire        serialCts_n
);
    // strobe width in cycles, rounded up, never below one
    localparam integer STROBE_RAW = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam integer STROBE_CYC = (STROBE_RAW < 1) ? 1 : STROBE_RAW;
    // the counter is four bits wide, so a very long strobe is cut to 15
    localparam integer STROBE_SAT = (STROBE_CYC > 15) ? 15 : STROBE_CYC;
    localparam [3:0]   STROBE_LEN = STROBE_SAT[3:0];

    // firmware RAM base; the window size follows the RAM address width
    localparam [15:0]  RAM_BASE   = `VME_RAM_ADDR;

    // read source codes
    localparam [1:0] SRC_STATUS = 2'h0;
    localparam [1:0] SRC_SERIAL = 2'h1;
    localparam [1:0] SRC_RAM    = 2'h2;
    localparam [1:0] SRC_NONE   = 2'h3;

    // four-byte window compare on the upper fourteen address bits
    function inWindow4;
        input [15:0] addr;
        input [15:0] base;
        begin
            inWindow4 = (addr[15:2] == base[15:2]);
        end
    endfunction

    // firmware RAM window compare, 512 bytes at the default width
    function inRamWindow;
        input [15:0] addr;
        begin
            inRamWindow = (addr[15:RAM_AW] == RAM_BASE[15:RAM_AW]);
        end
    endfunction

    // device-select latch and register state
    reg  [7:0] devSelect;
    reg  [7:0] voiceCtrl;
    reg  [7:0] modemCtrl;
    reg  [3:0] strobeCnt;
    reg  [1:0] rdSource;
    reg  [1:0] next_rdSource;

    // synchronised pin inputs and RAM read data
    wire       reqClean;
    wire       serIrqClean_n;
    wire       dcdClean_n;
    wire       dsrClean_n;
    wire [7:0] ramRdData;

    // decodes
    wire voiceSel;
    wire modemSel;
    wire hitDevSel;
    wire hitVoiceCtrl;
    wire hitVoiceStrb;
    wire hitModemCtrl;
    wire hitSerial;
    wire hitRam;
    wire voiceIrq;
    wire serialIrq;
    reg  [7:0] statusValue;

    assign voiceSel  = devSelect[`VME_SEL_VOICE_BIT]; // [RULE3]
    assign modemSel  = devSelect[`VME_SEL_MODEM_BIT]; // [RULE8]
    assign hitDevSel = (busAddr == `VME_DEVSEL_ADDR);
    assign hitVoiceCtrl = voiceSel &&
        inWindow4(busAddr, `VME_VOICE_CTRL_ADDR); // [RULE3] [RULE4]
    assign hitVoiceStrb = voiceSel &&
        inWindow4(busAddr, `VME_VOICE_STRB_ADDR); // [RULE3] [RULE5]
    assign hitModemCtrl = modemSel &&
        inWindow4(busAddr, `VME_MODEM_CTRL_ADDR); // [RULE8] [RULE9]
    assign hitSerial = modemSel &&
        inWindow4(busAddr, `VME_SERIAL_ADDR); // [RULE13]
    // the RAM answers whatever device is selected
    assign hitRam = inRamWindow(busAddr); // [RULE1]

    // only one status register; no separate internal-device copy exists.
    // the voice bit is the raw request, so polling works with irqs off
    always @* begin
        statusValue = 8'h00; // [RULE2]
        statusValue[`VME_STAT_VOICE_BIT]  = reqClean; // [RULE6] [RULE7]
        statusValue[`VME_STAT_SERIAL_BIT] = ~serIrqClean_n; // [RULE14]
    end

    // the voice interrupt is gated by its enable, the serial one is not
    assign voiceIrq  = reqClean && voiceCtrl[`VME_VOICE_IRQEN_BIT]; // [RULE18]
    assign serialIrq = !serIrqClean_n; // [RULE14]

    // clear-to-send is permanently asserted
    assign serialCts_n = 1'b0; // [RULE15]

    // every pin here is asynchronous; the reset values match the idle
    // levels so no false request or interrupt follows reset
    vme_sync #(
        .WIDTH (4),
        .INIT  (4'he)
    ) u_sync (
        .clk   (clk),
        .rst   (rst),
        .pinIn ({serialIrq_n, carrierDetect_n, ringDetect_n,
                 synthRequest}),
        .clean ({serIrqClean_n, dcdClean_n, dsrClean_n, reqClean})
    );

    vme_ram #(
        .AW    (RAM_AW),
        .DEPTH (RAM_DEPTH)
    ) u_ram (
        .clk    (clk),
        .addr   (busAddr[RAM_AW-1:0]),
        .wrEn   (busWrStrobe && hitRam), // [RULE1]
        .wrData (busWrData),
        .rdData (ramRdData)
    );

    // device-select latch; writes to D1FF pick the active device
    // writing zero deselects both devices, while D1FF reads still answer
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            devSelect <= `VME_DEVSEL_RESET;
        end else if (busWrStrobe && hitDevSel) begin
            devSelect <= busWrData;
        end
    end

    // voice control latch; write only, no read path
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            voiceCtrl <= `VME_VOICE_RESET;
        end else if (busWrStrobe && hitVoiceCtrl) begin
            voiceCtrl <= busWrData; // [RULE4]
        end
    end

    // strobe: hand the latched phoneme to the synthesizer; copying it
    // here means a later latch write cannot alter a phoneme in flight
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            synthPhoneme <= 6'h00;
            synthStrobe  <= 1'b0;
            strobeCnt    <= 4'h0;
        end else if (busWrStrobe && hitVoiceStrb) begin
            synthPhoneme <= voiceCtrl[`VME_PHONEME_MSB:0]; // [RULE5]
            synthStrobe  <= 1'b1;
            strobeCnt    <= STROBE_LEN;
        end else if (strobeCnt > 4'h1) begin
            strobeCnt <= strobeCnt - 4'h1;
        end else begin
            strobeCnt   <= 4'h0;
            synthStrobe <= 1'b0;
        end
    end

    // modem line control register, cleared by system reset
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            modemCtrl <= `VME_MODEM_RESET; // [RULE16]
        end else if (busWrStrobe && hitModemCtrl) begin
            modemCtrl <= busWrData; // [RULE9]
        end
    end

    // modem control fields; the host dials by toggling the hook bit
    // or by mixing in tones, so these follow writes with no filtering;
    // registered so the analog switches never see decode glitches
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            diskAttention  <= 1'b0;
            modemLoopback  <= 1'b0;
            phoneAudioOn   <= 1'b0;
            lineOffHook    <= 1'b0;
            auxAudioMix    <= 1'b0;
            directAudioCut <= 1'b0;
            modemOriginate <= 1'b0;
            carrierSquelch <= 1'b0;
        end else begin
            diskAttention  <= modemCtrl[`VME_MC_DISK_ATTENTION_BIT]; // [RULE9]
            modemLoopback  <= modemCtrl[`VME_MC_LOOP_BIT]; // [RULE10]
            phoneAudioOn   <= modemCtrl[`VME_MC_PHONE_BIT]; // [RULE10]
            lineOffHook    <= modemCtrl[`VME_MC_HOOK_BIT]; // [RULE10] [RULE17]
            auxAudioMix    <= modemCtrl[`VME_MC_MIX_BIT]; // [RULE11] [RULE17]
            directAudioCut <= modemCtrl[`VME_MC_CUT_BIT]; // [RULE11]
            modemOriginate <= modemCtrl[`VME_MC_ORIG_BIT]; // [RULE12]
            carrierSquelch <= modemCtrl[`VME_MC_SQUELCH_BIT]; // [RULE12]
        end
    end

    // serial interface access, presented one clock after the request
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            serialSelect <= 1'b0;
            serialRegSel <= 2'h0;
            serialWrite  <= 1'b0;
            serialWrData <= 8'h00;
        end else begin
            serialSelect <= (busWrStrobe || busRdStrobe) &&
                hitSerial; // [RULE13]
            serialRegSel <= busAddr[1:0];
            serialWrite  <= busWrStrobe && hitSerial;
            serialWrData <= busWrData;
        end
    end

    // serial interface reset and modem status lines
    // the serial chip is held in reset one clock past the bus reset
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            serialReset <= 1'b1; // [RULE16]
            serialDcd_n <= 1'b1;
            serialDsr_n <= 1'b1;
        end else begin
            serialReset <= 1'b0;
            serialDcd_n <= dcdClean_n; // [RULE15]
            serialDsr_n <= dsrClean_n; // [RULE15]
        end
    end

    // host interrupt: voice needs the enable, status bit does not
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            busIrq <= 1'b0;
        end else begin
            busIrq <= voiceIrq || serialIrq; // [RULE6] [RULE14] [RULE18]
        end
    end

    // choose which source answers a read
    always @* begin
        next_rdSource = SRC_NONE;
        if (hitDevSel) begin
            next_rdSource = SRC_STATUS;
        end else if (hitSerial) begin
            next_rdSource = SRC_SERIAL;
        end else if (hitRam) begin
            next_rdSource = SRC_RAM;
        end
    end

    // read stage one: note the source; RAM and serial data arrive next
    // write-only windows fall through to no source and never answer
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rdSource <= SRC_NONE;
        end else if (busRdStrobe) begin
            rdSource <= next_rdSource;
        end else begin
            rdSource <= SRC_NONE;
        end
    end

    // read stage two: drive the answer for one clock;
    // status is sampled at this edge so it is never older than one cycle
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            busRdData   <= 8'h00;
            busRdDataEn <= 1'b0;
        end else begin
            case (rdSource)
                SRC_STATUS: begin
                    busRdData   <= statusValue; // [RULE2] [RULE6] [RULE7] [RULE14]
                    busRdDataEn <= 1'b1;
                end
                SRC_SERIAL: begin
                    busRdData   <= serialRdData; // [RULE13]
                    busRdDataEn <= 1'b1;
                end
                SRC_RAM: begin
                    busRdData   <= ramRdData; // [RULE1]
                    busRdDataEn <= 1'b1;
                end
                default: begin
                    busRdData   <= 8'h00;
                    busRdDataEn <= 1'b0;
                end
            endcase
        end
    end
endmodule // vme_regs

// >>> shared/vme_map.vh
// address map, field positions, reset values and timing for the voice/modem block
`ifndef VME_MAP_VH
`define VME_MAP_VH

// device-select register, shared status on read
`define VME_DEVSEL_ADDR      16'hd1ff
`define VME_DEVSEL_RESET     8'h00
`define VME_SEL_VOICE_BIT    7
`define VME_SEL_MODEM_BIT    1

// voice registers (write only, decoded on the upper 14 address bits)
`define VME_VOICE_CTRL_ADDR  16'hd100
`define VME_VOICE_STRB_ADDR  16'hd104
`define VME_VOICE_IRQEN_BIT  7
`define VME_PHONEME_MSB      5
`define VME_VOICE_RESET      8'h00

// modem line control register and its fields
`define VME_MODEM_CTRL_ADDR  16'hd108
`define VME_MODEM_RESET      8'h00
`define VME_MC_DISK_ATTENTION_BIT      7
`define VME_MC_LOOP_BIT      6
`define VME_MC_PHONE_BIT     5
`define VME_MC_HOOK_BIT      4
`define VME_MC_MIX_BIT       3
`define VME_MC_CUT_BIT       2
`define VME_MC_ORIG_BIT      1
`define VME_MC_SQUELCH_BIT   0

// serial communications interface window
`define VME_SERIAL_ADDR      16'hd10c

// status bit positions within the shared status register
`define VME_STAT_VOICE_BIT   7
`define VME_STAT_SERIAL_BIT  1

// expansion firmware RAM
`define VME_RAM_ADDR         16'hd600
`define VME_RAM_DEPTH        512
`define VME_RAM_AW           9

// length of the strobe pulse given to the synthesizer in ns, and the clock in MHz
`define VME_STROBE_NS        40
`define VME_CLK_MHZ          50

`endif

// >>> hdl/vme_sync.v
// three-stage synchroniser with agreement filter for pin inputs
module vme_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    // clock and reset
    input  wire             clk,
    input  wire             rst,
    // pin side and clean side
    input  wire [WIDTH-1:0] pinIn,
    output reg  [WIDTH-1:0] clean
);
    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;
    reg [WIDTH-1:0] stage3;
    integer i;

    // stage1 feeds only stage2; a bit changes once stages 2 and 3 agree
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1 <= INIT;
            stage2 <= INIT;
            stage3 <= INIT;
            clean  <= INIT;
        end else begin
            stage1 <= pinIn;
            stage2 <= stage1;
            stage3 <= stage2;
            for (i = 0; i < WIDTH; i = i + 1) begin
                if (stage2[i] == stage3[i]) begin
                    clean[i] <= stage3[i];
                end
            end
        end
    end
endmodule // vme_sync

// >>> hdl/vme_ram.v
// flip-flop RAM for expansion firmware, one read port registered
module vme_ram #(
    parameter AW = 9,
    parameter DEPTH = 512
) (
    // clock
    input  wire          clk,
    // access
    input  wire [AW-1:0] addr,
    input  wire          wrEn,
    input  wire [7:0]    wrData,
    output reg  [7:0]    rdData
);
    // contents are not cleared by reset, like a real static RAM
    reg [7:0] mem [0:DEPTH-1];

    always @(posedge clk) begin
        if (wrEn) begin
            mem[addr] <= wrData;
        end
        rdData <= mem[addr];
    end
endmodule // vme_ram

// >>> bench/vme_regs_sva.sv
// assertions on the ports of the voice/modem register block
module vme_regs_sva (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // host bus
    input wire logic [15:0] busAddr,
    input wire logic [7:0]  busWrData,
    input wire logic        busWrStrobe,
    input wire logic        busRdStrobe,
    input wire logic [7:0]  busRdData,
    input wire logic        busRdDataEn,
    input wire logic        busIrq,
    // synthesizer
    input wire logic        synthRequest,
    input wire logic        synthStrobe,
    // modem control outputs
    input wire logic        diskAttention,
    input wire logic        modemLoopback,
    input wire logic        phoneAudioOn,
    input wire logic        lineOffHook,
    input wire logic        auxAudioMix,
    input wire logic        directAudioCut,
    input wire logic        modemOriginate,
    input wire logic        carrierSquelch,
    // serial interface
    input wire logic        serialSelect,
    input wire logic [1:0]  serialRegSel,
    input wire logic        serialIrq_n,
    input wire logic        serialReset,
    input wire logic        serialCts_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] devSel;
    wire  [7:0] modem = {diskAttention, modemLoopback, phoneAudioOn,
        lineOffHook, auxAudioMix, directAudioCut, modemOriginate,
        carrierSquelch};
    wire  [1:0] regLow = busAddr[1:0];
    wire        toModem = busWrStrobe && busAddr[15:2] == 14'h3442;
    // shadow of the select register, only the bus can change it
    always @(posedge clk or posedge rst)
        if (rst) devSel <= 8'h00;
        else if (busWrStrobe && busAddr == 16'hd1ff) devSel <= busWrData;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence reqHeld; synthRequest [*6]; endsequence
    // eight quiet samples cover the pin synchroniser plus the register
    sequence quietPins; (serialIrq_n && !synthRequest) [*8]; endsequence
    sequence statusRead; busRdStrobe && busAddr == 16'hd1ff; endsequence
    chk_strobe_pulse: assert property (busWrStrobe && devSel[7] &&
        busAddr[15:2] == 14'h3441 |=> synthStrobe [*2] ##1 !synthStrobe)
        else $error("synth strobe pulse wrong");
    chk_modem_fields: assert property (toModem && devSel[1]
        |=> ##1 modem == $past(busWrData, 2))
        else $error("modem control outputs wrong");
    chk_modem_ignored: assert property (toModem && !devSel[1]
        && !$past(busWrStrobe) |=> $stable(modem) [*2])
        else $error("unselected modem write took effect");
    chk_serial_map: assert property (busAddr[15:2] == 14'h3443
        && devSel[1] && (busWrStrobe || busRdStrobe)
        |=> serialSelect && serialRegSel == $past(regLow) ##1 !serialSelect)
        else $error("serial access not passed on");
    chk_status_answer: assert property (statusRead
        |=> ##1 busRdDataEn) else $error("status read unanswered");
    chk_status_poll: assert property (reqHeld ##0 statusRead
        |=> ##1 busRdData[7]) else $error("status bit 7 missing");
    chk_irq_quiet: assert property (quietPins |-> !busIrq)
        else $error("interrupt without cause");
    chk_cts_low: assert property (serialCts_n == 1'b0)
        else $error("cts not held low");
    chk_reset_clear: assert property ($past(rst)
        |-> serialReset && modem == 8'h00)
        else $error("reset did not clear modem side");
endmodule // vme_regs_sva

bind vme_regs vme_regs_sva vme_regs_sva_i (.clk, .rst, .busAddr,
    .busWrData, .busWrStrobe, .busRdStrobe, .busRdData, .busRdDataEn,
    .busIrq, .synthRequest, .synthStrobe, .diskAttention, .modemLoopback,
    .phoneAudioOn, .lineOffHook, .auxAudioMix, .directAudioCut,
    .modemOriginate, .carrierSquelch, .serialSelect, .serialRegSel,
    .serialIrq_n, .serialReset, .serialCts_n);

// >>> bench/vme_serial_model.sv
// behavioural serial interface chip standing beside the modem device
module vme_serial_model (
    // chip side
    input  wire logic       clk,
    input  wire logic       serialSelect,
    input  wire logic [1:0] serialRegSel,
    input  wire logic       serialWrite,
    input  wire logic [7:0] serialWrData,
    output wire logic [7:0] serialRdData,
    output wire logic       serialIrq_n,
    input  wire logic       serialReset,
    // bench control of the interrupt
    input  wire logic       irqReq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] regs [0:3];
    logic [7:0] lastRd = 8'h00;
    // released bus shows the inverse so a stale sample cannot match
    assign serialRdData = serialSelect ? regs[serialRegSel] : ~lastRd;
    assign serialIrq_n  = ~(irqReq && !serialReset);
    always @(posedge clk)
        if (serialReset) begin
            for (int i = 0; i < 4; i++) regs[i] <= 8'h00;
        end else if (serialSelect) begin
            if (serialWrite) regs[serialRegSel] <= serialWrData;
            lastRd <= serialRdData;
        end
endmodule // vme_serial_model

// >>> bench/vme_regs_bench.sv
// self-checking bench for the voice/modem register block
module vme_regs_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 0, rst = 1, rdGot;
    logic [15:0] busAddr = 0;
    logic [7:0]  busWrData = 0, busRdData, serialWrData, serialRdData;
    logic [7:0]  rdVal;
    wire  [7:0]  modem;
    logic        busWrStrobe = 0, busRdStrobe = 0, busRdDataEn, busIrq;
    logic        synthRequest = 0, synthStrobe, irqReq = 0;
    logic        carrierDetect_n = 1, ringDetect_n = 1;
    logic        serialSelect, serialWrite, serialIrq_n, serialReset;
    logic        serialDcd_n, serialDsr_n, serialCts_n;
    logic [5:0]  synthPhoneme;
    logic [1:0]  serialRegSel;
    int          failures = 0, checks_done = 0;
    vme_regs vme_regs_i (.clk, .rst, .busAddr, .busWrData, .busWrStrobe,
        .busRdStrobe, .busRdData, .busRdDataEn, .busIrq, .synthRequest,
        .synthPhoneme, .synthStrobe, .diskAttention(modem[7]),
        .modemLoopback(modem[6]), .phoneAudioOn(modem[5]),
        .lineOffHook(modem[4]), .auxAudioMix(modem[3]),
        .directAudioCut(modem[2]), .modemOriginate(modem[1]),
        .carrierSquelch(modem[0]), .carrierDetect_n, .ringDetect_n,
        .serialSelect, .serialRegSel, .serialWrite, .serialWrData,
        .serialRdData, .serialIrq_n, .serialReset, .serialDcd_n,
        .serialDsr_n, .serialCts_n);
    vme_serial_model vme_serial_model_i (.clk, .serialSelect, .serialRegSel,
        .serialWrite, .serialWrData, .serialRdData, .serialIrq_n,
        .serialReset, .irqReq);
    always #10 clk = ~clk;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        busAddr <= a;
        busWrData <= d;
        busWrStrobe <= 1'b1;
        @(posedge clk);
        busWrStrobe <= 1'b0;
        #1;
    endtask
    // a missing answer that was due ends the run at once
    task automatic rd(input logic [15:0] a, input logic must);
        rdGot = 0;
        @(posedge clk);
        busAddr <= a;
        busRdStrobe <= 1'b1;
        @(posedge clk);
        busRdStrobe <= 1'b0;
        for (int i = 0; i < 4 && !rdGot; i++) begin
            @(posedge clk);
            #1;
            if (busRdDataEn === 1'b1) begin
                rdGot = 1;
                rdVal = busRdData;
            end
        end
        if (must && !rdGot) begin
            failures++;
            tally_and_finish;
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        #1;
        check(modem, 8'h00);
        check(serialCts_n, 1'b0);
        rd(16'hd1ff, 1);
        check(rdVal, 8'h00);
        wr(16'hd108, 8'hff);
        idle(2);
        check(modem, 8'h00);
        wr(16'hd1ff, 8'h02);
        for (int i = 0; i < 8; i++) begin
            wr(16'hd108 + 16'(i % 4), 8'h01 << i);
            idle(1);
            check(modem, 8'h01 << i);
        end
        wr(16'hd10b, 8'h10);
        wr(16'hd10a, 8'h00);
        wr(16'hd108, 8'h10);
        wr(16'hd10d, 8'ha5);
        rd(16'hd10d, 1);
        check(rdVal, 8'ha5);
        rd(16'hd108, 0);
        check(rdGot, 1'b0);
        @(posedge clk) carrierDetect_n <= 1'b0;
        idle(6);
        check({serialDcd_n, serialDsr_n}, 2'b01);
        @(posedge clk) ringDetect_n <= 1'b0;
        idle(6);
        check({serialDcd_n, serialDsr_n}, 2'b00);
        @(posedge clk) irqReq <= 1'b1;
        idle(8);
        check(busIrq, 1'b1);
        rd(16'hd1ff, 1);
        check(rdVal, 8'h02);
        @(posedge clk) irqReq <= 1'b0;
        wr(16'hd1ff, 8'h80);
        wr(16'hd109, 8'h00);
        wr(16'hd102, 8'h2a);
        wr(16'hd107, 8'h00);
        check({synthStrobe, synthPhoneme}, 7'h6a);
        check(modem, 8'h10);
        @(posedge clk) synthRequest <= 1'b1;
        idle(8);
        check(busIrq, 1'b0);
        rd(16'hd1ff, 1);
        check(rdVal, 8'h80);
        wr(16'hd100, 8'h80);
        idle(2);
        check(busIrq, 1'b1);
        wr(16'hd1ff, 8'h02);
        wr(16'hd100, 8'h00);
        idle(2);
        check(busIrq, 1'b1);
        wr(16'hd600, 8'h3c);
        wr(16'hd7ff, 8'hc3);
        rd(16'hd600, 1);
        check(rdVal, 8'h3c);
        rd(16'hd7ff, 1);
        check(rdVal, 8'hc3);
        @(posedge clk) rst <= 1'b1;
        idle(2);
        check(modem, 8'h00);
        @(posedge clk) rst <= 1'b0;
        wr(16'hd1ff, 8'h02);
        rd(16'hd10d, 1);
        check(rdVal, 8'h00);
        tally_and_finish;
    end
endmodule // vme_regs_bench
